// >>> hw/bll_map.svh
// Purpose: Register indices, field positions, reset values and timing counts of the lighting link.
// Assumes: Register byte address is four times the register index.
// Notes: Definitions only; included by the principal design file.
`ifndef BLL_MAP_SVH
`define BLL_MAP_SVH

// ============================================================
// Register indices
`define BLL_IDX_PRESCALE 8'h40
`define BLL_IDX_FWD_ADDR 8'h41
`define BLL_IDX_FWD_DATA 8'h42
`define BLL_IDX_REPLY 8'h43
`define BLL_IDX_CONTROL 8'h44
`define BLL_IDX_STATUS 8'h45
`define BLL_ADDR_W 9

// ============================================================
// Control register fields
`define BLL_CTL_ENABLE 3
`define BLL_CTL_ACK 2
`define BLL_CTL_XMIT 1
`define BLL_CTL_FORCE 0

// ============================================================
// Status register fields
`define BLL_STS_IRQ_EN 7
`define BLL_STS_EOT 6
`define BLL_STS_ERR 5
`define BLL_STS_RX 4

// ============================================================
// Reset values
`define BLL_RST_BYTE 8'h00

// ============================================================
// Timing counts, in sample ticks and line phases
`define BLL_SAMPLES_PER_PHASE 16
`define BLL_SAMPLE_MAJ_A 4'h6
`define BLL_SAMPLE_MAJ_B 4'h7
`define BLL_SAMPLE_DECIDE 4'h8
`define BLL_FAIL_BITS 2
`define BLL_FAIL_TICKS (`BLL_FAIL_BITS * 2 * `BLL_SAMPLES_PER_PHASE)
`define BLL_RX_DATA_FIRST 6'h02
`define BLL_RX_STOP_FIRST 6'h22
`define BLL_RX_LAST 6'h25
`define BLL_TX_LAST 6'h15

`endif

// >>> hw/bll_pkg.sv
// Purpose: Types shared by the lighting link design.
// Assumes: Constants live in bll_map.svh.
// Notes: Core state travels as one packed struct.
package bll_pkg;

    // ============================================================
    // Sequencer states
    typedef enum logic [1:0] {
        BLL_IDLE,
        BLL_RX,
        BLL_WAIT,
        BLL_TX
    } bll_state_t;

    // ============================================================
    // Link core state
    typedef struct packed {
        bll_state_t state;
        logic xmit_mode;
        logic last_tx;
        logic [7:0] presc;
        logic [3:0] samp;
        logic line_prev;
        logic s6;
        logic s7;
        logic [5:0] phase_idx;
        logic [3:0] psh;
        logic [15:0] shreg;
        logic [6:0] low_cnt;
        logic tx_line;
        logic [7:0] fwd_addr;
        logic [7:0] fwd_data;
        logic [3:0] phase_cap;
        logic en_q;
        logic end_of_transfer_event;
        logic err;
    } bll_core_t;

    // ============================================================
    // Software visible control state
    typedef struct packed {
        logic [7:0] prescale;
        logic [7:0] reply;
        logic enable;
        logic xmit;
        logic force_tx;
        logic irq_en;
    } bll_ctl_t;

endpackage

// >>> hw/bll_top.sv
// Purpose: Bi-phase lighting link receiver and reply transmitter with Avalon-MM registers.
// Assumes: LINE_IN is synchronous to MCLK; idle line level is high.
// Notes: HALT freezes the link core; the bus keeps answering.
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "bll_map.svh"
`default_nettype none

// Operation
// - After reset the link waits in receive state for a logical-one start bit.
// - A 4-bit pre-shifter checks format; errors drop the frame, back to receive.
// - Good frame bits shift MSB first into 16 bits; bytes go to address/data registers.
// - A stored forward frame sets the end-of-transfer flag.
// - In transmit state the reply byte shifts out bi-phase, MSB first.
// - A finished reply frame sets the end-of-transfer flag.
// - No transfer starts while end-of-transfer is set, except after enable is cleared and set again; acknowledge releases it.
// - The line input always feeds the pre-shifter, in either state.
// - Force-transmit sends the reply byte without a forward frame, then flags end.
// - Normally a reply only follows a forward frame, never another reply.
// - The enable bit switches the link and resets the whole sequencer.
// - In receive state, line low for two bit periods sets the error flag.
// - Reading the status register clears the error flag.
// - Halt freezes link state except flag clears by acknowledge and status read; wait and active-halt change nothing.
// - End-of-transfer is the interrupt flag, gated by its enable bit.
// - Sixteen samples per phase; majority of 6,7,8; shift at the ninth sample.
// - Each line edge captures the sample count into status low bits, then clears it except in transmit state.
// - Data rate is MCLK divided by (N+1)*32, N the prescaler value.
// - Forward frame: start one, address byte, data byte, two high stop bits.
// - Reply frame: start one, data byte, two high stop bits.
// - Acknowledge clears end-of-transfer and reads back as zero.
// - Receive flag reads one in receive state, zero in transmit state.
module bll_top
    import bll_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic [`BLL_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic LINE_IN,
    output logic LINE_OUT,
    input wire logic HALT,
    output logic IRQ
);

    // ============================================================
    // Address decode

    // Byte address of a register from its index.
    function automatic logic [`BLL_ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        reg_addr = `BLL_ADDR_W'({idx, 2'b00});
    endfunction

    logic req;
    logic acc_q;
    logic next_acc_q;
    logic accept;
    logic wr_lane;
    logic [7:0] wbyte;
    logic wr_ctl;
    logic rd_status;
    logic ack_pulse;
    bll_ctl_t ctl;
    bll_ctl_t next_ctl;
    bll_core_t core;
    bll_core_t next_core;
    logic [31:0] next_rdata;
    logic [7:0] rd_byte;

    // Every access waits one cycle so read data can come from a flip-flop.
    assign req = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req & ~acc_q;
    assign accept = req & acc_q;
    assign wr_lane = AVS_WRITE & accept & AVS_BYTEENABLE[0];
    assign wbyte = AVS_WRITEDATA[7:0];
    assign wr_ctl = wr_lane & (AVS_ADDRESS == reg_addr(`BLL_IDX_CONTROL));
    assign ack_pulse = wr_ctl & wbyte[`BLL_CTL_ACK];
    assign rd_status = AVS_READ & accept & (AVS_ADDRESS == reg_addr(`BLL_IDX_STATUS));

    // ============================================================
    // Bus slave and control registers

    // Read mux; unmapped addresses read zero and ignore writes.
    always_comb
    begin
        rd_byte = `BLL_RST_BYTE;
        case (AVS_ADDRESS)
            reg_addr(`BLL_IDX_PRESCALE): rd_byte = ctl.prescale;
            reg_addr(`BLL_IDX_FWD_ADDR): rd_byte = core.fwd_addr;
            reg_addr(`BLL_IDX_FWD_DATA): rd_byte = core.fwd_data;
            reg_addr(`BLL_IDX_REPLY): rd_byte = ctl.reply;
            reg_addr(`BLL_IDX_CONTROL): rd_byte = {4'h0, ctl.enable, 1'b0, ctl.xmit, ctl.force_tx};
            reg_addr(`BLL_IDX_STATUS): rd_byte = {ctl.irq_en, core.end_of_transfer_event, core.err,
                                                  ~core.xmit_mode, core.phase_cap};
            default: rd_byte = `BLL_RST_BYTE;
        endcase
    end

    // Next values of the bus handshake, read data and control bits.
    always_comb
    begin
        next_acc_q = req & ~acc_q;
        next_rdata = AVS_READDATA;
        next_ctl = ctl;
        if (AVS_READ & ~acc_q)
        begin
            next_rdata = {24'h000000, rd_byte};
        end
        if (wr_lane)
        begin
            case (AVS_ADDRESS)
                reg_addr(`BLL_IDX_PRESCALE): next_ctl.prescale = wbyte;
                reg_addr(`BLL_IDX_REPLY): next_ctl.reply = wbyte;
                reg_addr(`BLL_IDX_CONTROL):
                begin
                    next_ctl.enable = wbyte[`BLL_CTL_ENABLE];
                    next_ctl.xmit = wbyte[`BLL_CTL_XMIT];
                    next_ctl.force_tx = wbyte[`BLL_CTL_FORCE];
                end
                reg_addr(`BLL_IDX_STATUS): next_ctl.irq_en = wbyte[`BLL_STS_IRQ_EN];
                default: next_ctl = ctl;
            endcase
        end
    end

    // Registers of the bus group.
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            acc_q <= 1'b0;
            AVS_READDATA <= 32'h00000000;
            ctl <= '0;
        end
        else
        begin
            acc_q <= next_acc_q;
            AVS_READDATA <= next_rdata;
            ctl <= next_ctl;
        end
    end

    // ============================================================
    // Link core

    logic tick;
    logic edge_seen;
    logic maj;
    logic phase_done;
    logic [3:0] psh_new;
    logic odd_phase;
    logic tx_bit;
    logic tx_level;
    logic rx_side;

    // Sample tick: prescaler counts 0..N, giving MCLK/(N+1) samples, 16 per phase.
    assign tick = (core.presc == ctl.prescale);
    assign edge_seen = tick & (LINE_IN != core.line_prev);
    // Phase level is the majority of samples 6, 7 and 8, decided at the ninth sample.
    assign maj = (core.s6 & core.s7) | (core.s6 & LINE_IN) | (core.s7 & LINE_IN);
    assign phase_done = tick & (core.samp == `BLL_SAMPLE_DECIDE);
    assign psh_new = {core.psh[2:0], maj};
    assign odd_phase = core.phase_idx[0];
    assign rx_side = ~core.xmit_mode;
    // Reply bit being sent and the line level for the current phase.
    assign tx_bit = core.shreg[15];
    always_comb
    begin
        if (core.phase_idx < `BLL_RX_DATA_FIRST)
        begin
            tx_level = odd_phase; // Start bit: low then high.
        end
        else if (core.phase_idx < 6'h12)
        begin
            tx_level = odd_phase ? tx_bit : ~tx_bit;
        end
        else
        begin
            tx_level = 1'b1; // Stop bits stay high with no phase change.
        end
    end

    // Next core state; while HALT is high everything holds except flag clears by acknowledge and status read.
    always_comb
    begin
        next_core = core;
        next_core.en_q = ctl.enable;
        // Acknowledge clears end-of-transfer unless a new end arrives in the same cycle.
        if (ack_pulse)
        begin
            next_core.end_of_transfer_event = 1'b0;
        end
        if (rd_status)
        begin
            next_core.err = 1'b0;
        end
        if (HALT)
        begin
            next_core = core;
            next_core.end_of_transfer_event = core.end_of_transfer_event & ~ack_pulse;
            next_core.err = core.err & ~rd_status;
        end
        else if (!ctl.enable)
        begin
            // Disabled: sequencer held in its reset state, line released high.
            next_core.state = BLL_IDLE;
            next_core.xmit_mode = 1'b0;
            next_core.last_tx = 1'b0;
            next_core.presc = 8'h00;
            next_core.samp = 4'h0;
            next_core.line_prev = 1'b1;
            next_core.psh = 4'h0;
            next_core.phase_idx = 6'h00;
            next_core.low_cnt = 7'h00;
            next_core.tx_line = 1'b1;
        end
        else if (!core.en_q)
        begin
            // Enable just rose: fresh sequencer, forced mode goes straight to transmit.
            next_core.presc = 8'h00;
            next_core.samp = 4'h0;
            next_core.phase_idx = 6'h00;
            if (ctl.force_tx)
            begin
                next_core.state = BLL_TX;
                next_core.xmit_mode = 1'b1;
                next_core.shreg = {ctl.reply, 8'h00};
            end
        end
        else
        begin
            next_core.presc = tick ? 8'h00 : 8'(core.presc + 8'h01);
            if (tick)
            begin
                next_core.line_prev = LINE_IN;
                next_core.samp = 4'(core.samp + 4'h1);
                if (core.samp == `BLL_SAMPLE_MAJ_A)
                begin
                    next_core.s6 = LINE_IN;
                end
                if (core.samp == `BLL_SAMPLE_MAJ_B)
                begin
                    next_core.s7 = LINE_IN;
                end
                // Line failure watch counts low samples in receive state only.
                if (LINE_IN | ~rx_side)
                begin
                    next_core.low_cnt = 7'h00;
                end
                else if (core.low_cnt == 7'(`BLL_FAIL_TICKS - 1))
                begin
                    next_core.err = 1'b1;
                    next_core.low_cnt = 7'h00;
                end
                else
                begin
                    next_core.low_cnt = 7'(core.low_cnt + 7'h01);
                end
            end
            if (edge_seen)
            begin
                // Edges resynchronise the phase timing to the incoming line.
                next_core.phase_cap = core.samp;
                next_core.samp = 4'h0;
            end
            if (phase_done)
            begin
                next_core.psh = psh_new;
            end
            case (core.state)
                BLL_IDLE:
                begin
                    // A falling edge opens the low half of a start bit.
                    if (edge_seen & ~LINE_IN)
                    begin
                        next_core.state = BLL_RX;
                        next_core.phase_idx = 6'h00;
                    end
                end
                BLL_RX:
                begin
                    if (phase_done)
                    begin
                        next_core.phase_idx = 6'(core.phase_idx + 6'h01);
                        if (core.phase_idx == 6'h01 && psh_new[1:0] != 2'b01)
                        begin
                            next_core.err = 1'b1;
                            next_core.state = BLL_IDLE;
                        end
                        else if (odd_phase && core.phase_idx < `BLL_RX_STOP_FIRST)
                        begin
                            if (psh_new[1] == psh_new[0])
                            begin
                                next_core.err = 1'b1;
                                next_core.state = BLL_IDLE;
                            end
                            else if (core.phase_idx > `BLL_RX_DATA_FIRST)
                            begin
                                next_core.shreg = {core.shreg[14:0], maj};
                            end
                        end
                        else if (core.phase_idx == `BLL_RX_LAST)
                        begin
                            if (psh_new == 4'hf)
                            begin
                                next_core.fwd_addr = core.shreg[15:8];
                                next_core.fwd_data = core.shreg[7:0];
                                next_core.end_of_transfer_event = 1'b1;
                                next_core.last_tx = 1'b0;
                                next_core.state = BLL_WAIT;
                            end
                            else
                            begin
                                next_core.err = 1'b1;
                                next_core.state = BLL_IDLE;
                            end
                        end
                    end
                end
                BLL_WAIT:
                begin
                    // Nothing starts until software acknowledges the last transfer.
                    if (ack_pulse)
                    begin
                        next_core.phase_idx = 6'h00;
                        next_core.samp = 4'h0;
                        if (next_ctl.force_tx | (next_ctl.xmit & ~core.last_tx))
                        begin
                            next_core.state = BLL_TX;
                            next_core.xmit_mode = 1'b1;
                            next_core.shreg = {ctl.reply, 8'h00};
                        end
                        else
                        begin
                            // A second reply in a row is refused; the link listens again.
                            next_core.state = BLL_IDLE;
                            next_core.xmit_mode = 1'b0;
                        end
                    end
                end
                BLL_TX:
                begin
                    next_core.tx_line = tx_level;
                    if (tick && core.samp == 4'hf)
                    begin
                        next_core.phase_idx = 6'(core.phase_idx + 6'h01);
                        if (odd_phase && core.phase_idx >= `BLL_RX_DATA_FIRST
                            && core.phase_idx < 6'h12)
                        begin
                            next_core.shreg = {core.shreg[14:0], 1'b0};
                        end
                        if (core.phase_idx == `BLL_TX_LAST)
                        begin
                            next_core.end_of_transfer_event = 1'b1;
                            next_core.last_tx = 1'b1;
                            next_core.tx_line = 1'b1;
                            next_core.state = BLL_WAIT;
                        end
                    end
                end
                default: next_core.state = BLL_IDLE;
            endcase
            // The transmitter times itself, so line edges must not disturb its counter.
            if (core.state == BLL_TX)
            begin
                next_core.samp = tick ? 4'(core.samp + 4'h1) : core.samp;
            end
        end
    end

    // Registers of the core group.
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            core <= '{state: BLL_IDLE, line_prev: 1'b1, tx_line: 1'b1, default: '0};
        end
        else
        begin
            core <= next_core;
        end
    end

    // ============================================================
    // Outputs

    // Line driven from a flip-flop; interrupt is flag gated by enable.
    assign LINE_OUT = core.tx_line;
    assign IRQ = core.end_of_transfer_event & ctl.irq_en;

endmodule

`default_nettype wire

// >>> tb/bll_checker.sv
// Purpose: Port-level assertions for the lighting link.
// Assumes: Reply traffic runs with a prescaler of zero, 16 clocks per phase.
// Notes: Bound to every bll_top instance below the module.
`timescale 1ns/1ps
`include "bll_map.svh"
`default_nettype none
module bll_checker (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic [`BLL_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic LINE_OUT,
    input wire logic IRQ
);
    // ============================================================
    // Helpers
    // Counts low clocks on the reply line; a counter avoids a huge repetition.
    logic [6:0] low_run;
    always_ff @(posedge MCLK)
    begin
        low_run <= (!RESET_N || LINE_OUT) ? 7'h00 : low_run + 7'h01;
    end
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);
    // ============================================================
    // Bus and link properties
    property p_wait_one;
        $rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait state count wrong");
    property p_no_req;
        !(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST;
    endproperty
    a_no_req: assert property (p_no_req) else $error("waitrequest without request");
    property p_read_hi;
        AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000;
    endproperty
    a_read_hi: assert property (p_read_hi) else $error("read data upper bits set");
    property p_reset_idle;
        $rose(RESET_N) |-> LINE_OUT && !IRQ;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
    property p_ack_clears;
        AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 9'h110 && AVS_WRITEDATA[2]
            && AVS_BYTEENABLE[0] |=> !IRQ;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack left irq high");
    property p_irq_cause;
        $fell(IRQ) |-> $past(AVS_WRITE && !AVS_WAITREQUEST);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq fell without write");
    property p_phase_min;
        $changed(LINE_OUT) |=> $stable(LINE_OUT) [*8];
    endproperty
    a_phase_min: assert property (p_phase_min) else $error("reply phase too short");
    property p_low_max;
        low_run < 7'h21;
    endproperty
    a_low_max: assert property (p_low_max) else $error("reply line low too long");
endmodule
bind bll_top bll_checker i_chk (.MCLK(MCLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .LINE_OUT(LINE_OUT), .IRQ(IRQ));
`default_nettype wire

// >>> tb/bll_line_master.sv
// Purpose: Network controller model that drives forward frames onto the line.
// Assumes: Line idles high between frames.
// Notes: Can corrupt one bit or hold the line low on command.
`timescale 1ns/1ps
`default_nettype none
module bll_line_master (
    input wire logic clk,
    output logic line
);
    initial line = 1'b1;
    // One phase level, changed just after an edge and held n clocks.
    task automatic ph_out(input logic v, input int n);
        line <= v;
        repeat (n) @(posedge clk);
    endtask
    // Start one, sixteen bits MSB first, four high stop phases; bad makes halves equal.
    task automatic send(input logic [15:0] w, input int n, input int bad);
        @(posedge clk);
        ph_out(1'b0, n);
        ph_out(1'b1, n);
        for (int i = 15; i >= 0; i--)
        begin
            ph_out(!w[i], n);
            ph_out(w[i] ^ (i == bad), n);
        end
        ph_out(1'b1, 4 * n);
    endtask
    // Line failure: held low, then idle again.
    task automatic fail(input int n);
        @(posedge clk);
        ph_out(1'b0, n);
        ph_out(1'b1, 128);
    endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the lighting link.
// Assumes: Prescaler zero except one frame at one.
// Notes: Reads note their expectation in a queue; a monitor compares.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic MCLK, RESET_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, LINE_IN, LINE_OUT, IRQ, HALT;
    logic [8:0] AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA;
    logic [3:0] AVS_BYTEENABLE;
    logic [24:0] q[$];
    logic [24:0] t;
    logic [7:0] r;
    logic [15:0] w;
    int miscompares = 0;
    int n_checks = 0;
    int lows;
    bll_top i_dut (.MCLK(MCLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .LINE_IN(LINE_IN), .LINE_OUT(LINE_OUT),
        .HALT(HALT), .IRQ(IRQ));
    bll_line_master i_master (.clk(MCLK), .line(LINE_IN));
    // ============================================================
    // Clock, checks and bus tasks
    initial
    begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    // Holds the request until waitrequest is sampled low; only the watchdog ends a hang.
    task automatic bus(input logic [8:0] a, input logic wen, input logic [7:0] d,
        input logic [3:0] be);
        @(posedge MCLK);
        AVS_ADDRESS <= a;
        AVS_WRITE <= wen;
        AVS_READ <= !wen;
        AVS_WRITEDATA <= {24'h000000, d};
        AVS_BYTEENABLE <= be;
        do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 4'h1);
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e, input logic [7:0] m);
        q.push_back({a, e, m});
        bus(a, 1'b0, 8'h00, 4'h1);
    endtask
    task automatic wirq();
        for (int n = 0; n < 3000 && IRQ !== 1'b1; n++) @(posedge MCLK);
        chk("irq", 32'h1, {31'h0, IRQ});
    endtask
    // Decodes a reply: start second phase, eight data bits, second stop phase.
    task automatic rx_reply(input logic [7:0] e);
        logic [9:0] b;
        for (int n = 0; n < 3000 && LINE_OUT !== 1'b0; n++) @(posedge MCLK);
        repeat (24) @(posedge MCLK);
        for (int i = 9; i >= 0; i--)
        begin
            b[i] = LINE_OUT;
            repeat (32) @(posedge MCLK);
        end
        chk("reply bits", {22'h0, 1'b1, e, 1'b1}, {22'h0, b});
    endtask
    task automatic fwd(input logic [15:0] f, input int n);
        i_master.send(f, n, -1);
        wirq();
        rd(9'h104, f[15:8], 8'hff);
        rd(9'h108, f[7:0], 8'hff);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Takes the oldest note when a read is accepted; upper bits must be zero.
    always @(posedge MCLK)
    begin
        if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0)
        begin
            t = q.pop_front();
            chk($sformatf("reg %h", t[24:16]), {24'h0, t[15:8] & t[7:0]},
                AVS_READDATA & {24'hffffff, t[7:0]});
        end
    end
    // A hang counts as a mismatch and ends the run the normal way.
    initial
    begin
        repeat (30000) @(posedge MCLK);
        miscompares++;
        finish_test();
    end
    // ============================================================
    // Scenarios
    initial
    begin
        {RESET_N, HALT, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, AVS_BYTEENABLE} = '0;
        void'($urandom(32'h09b9));
        repeat (20) @(posedge MCLK);
        RESET_N <= 1'b1;
        for (int i = 0; i < 4; i++) rd(9'h100 + 9'(4 * i), 8'h00, 8'hff);
        rd(9'h114, 8'h00, 8'he0);
        rd(9'h1fc, 8'h00, 8'hff);
        r = 8'($urandom);
        w = 16'($urandom);
        wr(9'h100, r);
        rd(9'h100, r, 8'hff);
        wr(9'h104, r);
        rd(9'h104, 8'h00, 8'hff);
        bus(9'h10c, 1'b1, r, 4'h0);
        rd(9'h10c, 8'h00, 8'hff);
        wr(9'h100, 8'h00);
        wr(9'h114, 8'h80);
        wr(9'h110, 8'h08);
        fwd(w, 16);
        rd(9'h114, 8'hcf, 8'hef);
        wr(9'h10c, r);
        wr(9'h110, 8'h0e);
        rd(9'h114, 8'h00, 8'h50);
        rx_reply(r);
        wirq();
        wr(9'h110, 8'h0e);
        lows = 0;
        repeat (600)
        begin
            @(posedge MCLK);
            lows += int'(LINE_OUT !== 1'b1);
        end
        chk("refused reply", 32'h0, lows);
        rd(9'h114, 8'h10, 8'h50);
        wr(9'h100, 8'h01);
        fwd(~w, 32);
        wr(9'h100, 8'h00);
        wr(9'h110, 8'h0c);
        i_master.send(w, 16, 5);
        rd(9'h114, 8'h20, 8'h60);
        rd(9'h114, 8'h00, 8'h20);
        rd(9'h104, ~w[15:8], 8'hff);
        HALT <= 1'b1;
        i_master.fail(80);
        rd(9'h114, 8'h00, 8'h20);
        HALT <= 1'b0;
        i_master.fail(80);
        rd(9'h114, 8'h20, 8'h20);
        wr(9'h110, 8'h00);
        wr(9'h10c, ~r);
        wr(9'h110, 8'h09);
        rx_reply(~r);
        wirq();
        lows = 0;
        repeat (400) @(posedge MCLK) lows += int'(LINE_OUT !== 1'b1);
        chk("held reply", 32'h0, lows);
        wr(9'h110, 8'h0d);
        rx_reply(~r);
        wirq();
        wr(9'h110, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
